// ### can_cfg_pkg.sv
// constants, states and register map of the can controller
// assumes a 20 MHz mclk and a 12-bit AXI4-Lite byte address
package can_cfg_pkg;
	// ==========================================================
	// register map, byte addresses
	localparam int          ADDR_W     = 12;
	localparam logic [11:0] CTL_OFF    = 12'h000;
	localparam logic [11:0] STAT_OFF   = 12'h004;
	localparam logic [11:0] TSTAT_OFF  = 12'h008;
	localparam logic [11:0] RF0_OFF    = 12'h00C;
	localparam logic [11:0] RF1_OFF    = 12'h010;
	localparam logic [11:0] BT_OFF     = 12'h01C;
	localparam logic [11:0] TIMER_OFF  = 12'h020;
	localparam logic [11:0] FACT_OFF   = 12'h024;
	localparam logic [11:0] FFIFO_OFF  = 12'h028;
	localparam logic [11:0] MB_BASE    = 12'h180;
	localparam logic [11:0] RXM_BASE   = 12'h1B0;
	localparam logic [11:0] FLT_BASE   = 12'h240;
	// ==========================================================
	// field positions, sizes and response codes
	localparam int CTL_INIT   = 0;
	localparam int CTL_SLEEP  = 1;
	localparam int CTL_TFO    = 2;
	localparam int CTL_AWU    = 5;
	localparam int CTL_TTC    = 7;
	localparam int STAT_INIT  = 0;
	localparam int STAT_SLEEP = 1;
	localparam int BT_LOOP    = 30;
	localparam int BT_SILENT  = 31;
	localparam int MBI_TXREQ  = 0;
	localparam int TS_SENT    = 0;
	localparam int TS_OK      = 1;
	localparam int TS_ARB     = 2;
	localparam int TS_ERR     = 3;
	localparam int TS_EMPTY   = 26;
	localparam int RF_FULL    = 3;
	localparam int RF_REL     = 5;
	localparam int NUM_MB     = 3;
	localparam int NUM_RF     = 2;
	localparam logic [1:0] RF_DEPTH = 2'h3;
	localparam int NUM_FLT    = 28;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// ==========================================================
	// timing: 1 Mbit/s bit time on the 50 ns clock
	localparam int CLK_NS     = 50;
	localparam int BIT_NS     = 1000;
	localparam int BIT_CYC    = BIT_NS / CLK_NS;
	localparam logic [4:0] BIT_LAST = 5'(BIT_CYC - 1);
	localparam int FRAME_BITS = 97;
	localparam logic [6:0] FRAME_LAST = 7'(FRAME_BITS - 1);
	localparam logic [6:0] ARB_END = 7'h21;
	// ==========================================================
	// state codes
	typedef enum logic [2:0] {
		M_SLEEP = 3'h1, M_INIT = 3'h2, M_NORM = 3'h4
	} mode_e;
	typedef enum logic [3:0] {
		MB_EMPTY = 4'h1, MB_PEND = 4'h2, MB_SCHED = 4'h4, MB_TX = 4'h8
	} mb_e;
	typedef enum logic [2:0] {
		E_IDLE = 3'h1, E_TX = 3'h2, E_RX = 3'h4
	} eng_e;
endpackage

// ### can_ctrl.sv
// can controller: working modes, mailboxes, receive fifos, filters
// assumes an AXI4-Lite master on mclk and a transceiver on can_rx/tx
//
// Function
// - after reset the controller sits in sleep with its engine stopped
// - setting sleep request enters sleep, then sleep status flag sets
// - auto wakeup plus bus activity, or clearing sleep request, leaves
// - request bits pick mode: init only, none normal, sleep only
// - setting init request enters init, then init status flag sets
// - leaving normal mode waits for the frame in progress to end
// - silent mode receives, never sends, holds tx pin high
// - loopback feeds sent frames to receive fifos, rx pin ignored
// - loopback plus silent: nothing sent or received, tx high, rx ignored
// - neither loopback nor silent set means normal communication
// - three mailboxes, each with id, property and two data words
// - mailbox walks empty, pending, scheduled if several wait, transmit, empty
// - scheduler picks one pending mailbox; only it transmits
// - sent flag sets once the mailbox frame has gone out
// - sent-ok flag sets only when the frame went out clean
// - arbitration-lost flag sets when arbitration is lost
// - error flag sets when a bus error breaks the transmission
// - two hardware fifos, three received frames each
// - 28 filter banks accept wanted frames, drop the rest
// - 16-bit free timer captured at start of frame, rx and tx
// - time mode stamps last two data bytes, no retransmission
// - order bit 0: lowest id first; 1: request order
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module can_ctrl (
	input  wire logic                           mclk,
	input  wire logic                           rst,
	input  wire logic [can_cfg_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                           awvalid,
	output logic                                awready,
	input  wire logic [31:0]                    wdata,
	input  wire logic [3:0]                     wstrb,
	input  wire logic                           wvalid,
	output logic                                wready,
	output logic [1:0]                          bresp,
	output logic                                bvalid,
	input  wire logic                           bready,
	input  wire logic [can_cfg_pkg::ADDR_W-1:0] araddr,
	input  wire logic                           arvalid,
	output logic                                arready,
	output logic [31:0]                         rdata,
	output logic [1:0]                          rresp,
	output logic                                rvalid,
	input  wire logic                           rready,
	input  wire logic                           can_rx,
	output logic                                can_tx,
	output logic                                proto_clk_en
);
	import can_cfg_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		mode_e                   mode;
		logic                    init_request;
		logic                    sleep_request;
		logic                    auto_wakeup_enable;
		logic                    fifo_order_select;
		logic                    ttc;
		logic                    silent_select;
		logic                    loopback_select;
		logic [2:0][31:0]        mb_id;
		logic [2:0][31:0]        mb_prop;
		logic [2:0][31:0]        mb_dlo;
		logic [2:0][31:0]        mb_dhi;
		logic [2:0][3:0]         mb_st;
		logic [2:0][1:0]         ord;
		logic [2:0][3:0]         tstat;
		logic [15:0]             timer;
		logic [15:0]             ts;
		eng_e                    eng;
		logic [6:0]              bitn;
		logic [4:0]              bcnt;
		logic [1:0]              cur;
		logic [96:0]             sh;
		logic                    txpin;
		logic [1:0][2:0][111:0]  rf;
		logic [1:0][1:0]         rf_cnt;
		logic [1:0][1:0]         rf_head;
		logic [27:0][31:0]       f_id;
		logic [27:0][31:0]       f_mask;
		logic [27:0]             f_act;
		logic [27:0]             f_fifo;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    rvalid;
		logic [1:0]              rresp;
		logic [31:0]             rdata;
		logic                    rx_s1;
		logic                    rx_s2;
	} st_s;

	st_s        st;
	st_s        next_st;
	logic       wr_go;
	logic       rd_go;
	logic       rx_int;
	logic       bit_end;
	logic       any_rdy;
	logic [1:0] sel;
	logic [1:0] n_rdy;

	// ==========================================================
	// helpers
	function automatic logic [31:0] wmerge(input logic [31:0] o,
			input logic [31:0] d, input logic [3:0] b);
		for (int k = 0; k < 4; k++) begin
			if (b[k]) begin
				o[8*k +: 8] = d[8*k +: 8];
			end
		end
		return o;
	endfunction

	// read decode: {hit, word}
	function automatic logic [32:0] rdmux(input st_s x,
			input logic [11:0] a);
		logic [7:0]   m;
		logic [7:0]   q;
		logic [11:0]  f;
		logic [32:0]  r;
		logic [111:0] e;
		m = a[11:4] - MB_BASE[11:4];
		q = a[11:4] - RXM_BASE[11:4];
		f = a - FLT_BASE;
		e = x.rf[q[0]][x.rf_head[q[0]]];
		r = {1'b1, 32'h0};
		case ({a[11:2], 2'h0})
			CTL_OFF: begin
				r[CTL_INIT] = x.init_request;
				r[CTL_SLEEP] = x.sleep_request;
				r[CTL_TFO] = x.fifo_order_select;
				r[CTL_AWU] = x.auto_wakeup_enable;
				r[CTL_TTC] = x.ttc;
			end
			STAT_OFF: begin
				r[STAT_INIT] = x.mode == M_INIT;
				r[STAT_SLEEP] = x.mode == M_SLEEP;
			end
			TSTAT_OFF: begin
				for (int i = 0; i < NUM_MB; i++) begin
					r[8*i +: 4] = x.tstat[i];
					r[TS_EMPTY+i] = x.mb_st[i] == MB_EMPTY;
				end
			end
			RF0_OFF, RF1_OFF: begin
				r[1:0] = x.rf_cnt[a[4]];
				r[RF_FULL] = x.rf_cnt[a[4]] == RF_DEPTH;
			end
			BT_OFF: begin
				r[BT_LOOP] = x.loopback_select;
				r[BT_SILENT] = x.silent_select;
			end
			TIMER_OFF: r[15:0] = x.timer;
			FACT_OFF:  r[27:0] = x.f_act;
			FFIFO_OFF: r[27:0] = x.f_fifo;
			default: begin
				if (m < 8'h03) begin
					case (a[3:2])
						2'h0: r[31:0] = {x.mb_id[m[1:0]][31:1],
							x.mb_st[m[1:0]] != MB_EMPTY};
						2'h1: r[31:0] = x.mb_prop[m[1:0]];
						2'h2: r[31:0] = x.mb_dlo[m[1:0]];
						default: r[31:0] = x.mb_dhi[m[1:0]];
					endcase
				end else if (q < 8'h02) begin
					case (a[3:2])
						2'h0: r[31:0] = e[111:80];
						2'h1: r[31:0] = {e[15:0], 16'h0};
						2'h2: r[31:0] = e[79:48];
						default: r[31:0] = e[47:16];
					endcase
				end else if (f < 12'(NUM_FLT * 8)) begin
					r[31:0] = a[2] ? x.f_mask[f[7:3]] : x.f_id[f[7:3]];
				end else begin
					r[32] = 1'b0;
				end
			end
		endcase
		return r;
	endfunction

	// ==========================================================
	// bus handshakes: address and data are taken together
	assign wr_go   = awvalid && wvalid && !st.bvalid;
	assign awready = wr_go;
	assign wready  = wr_go;
	assign rd_go   = arvalid && !st.rvalid;
	assign arready = rd_go;
	assign bvalid  = st.bvalid;
	assign bresp   = st.bresp;
	assign rvalid  = st.rvalid;
	assign rresp   = st.rresp;
	assign rdata   = st.rdata;
	assign can_tx  = st.txpin;
	assign proto_clk_en = st.mode != M_SLEEP;

	// loopback cuts the pin off and listens to our own bit
	assign rx_int = st.loopback_select ?
		(st.eng == E_TX ? st.sh[96] : 1'b1) : st.rx_s2;
	assign bit_end = st.bcnt == BIT_LAST;

	// ==========================================================
	// next state
	always_comb begin
		logic [32:0] v;
		logic [31:0] c;
		logic [7:0]  mi;
		logic [11:0] fi;
		logic        hit;
		logic        ff;
		logic        arb;
		logic [1:0]  slot;
		v = rdmux(st, awaddr);
		c = wmerge(32'h0, wdata, wstrb);
		mi = awaddr[11:4] - MB_BASE[11:4];
		fi = awaddr - FLT_BASE;
		hit = 1'b0;
		ff = 1'b0;
		arb = 1'b0;
		slot = 2'h0;
		next_st = st;
		// scheduler: lowest id or oldest request, lower number on ties
		any_rdy = 1'b0;
		sel = 2'h0;
		n_rdy = 2'h0;
		for (int i = 0; i < NUM_MB; i++) begin
			if (st.mb_st[i] == MB_PEND || st.mb_st[i] == MB_SCHED) begin
				if (!any_rdy || (st.fifo_order_select ?
						st.ord[i] < st.ord[sel] :
						st.mb_id[i][31:1] < st.mb_id[sel][31:1])) begin
					sel = 2'(i);
				end
				any_rdy = 1'b1;
			end
		end
		// only the second stage of the synchroniser is read
		next_st.rx_s1 = can_rx;
		next_st.rx_s2 = st.rx_s1;
		if (st.bvalid && bready) begin
			next_st.bvalid = 1'b0;
		end
		if (st.rvalid && rready) begin
			next_st.rvalid = 1'b0;
		end
		if (st.mode != M_SLEEP) begin
			next_st.timer = st.timer + 16'h0001;
		end
		// register writes
		if (wr_go) begin
			next_st.bvalid = 1'b1;
			next_st.bresp = v[32] ? RESP_OKAY : RESP_DECERR;
			v[31:0] = wmerge(v[31:0], wdata, wstrb);
			case ({awaddr[11:2], 2'h0})
				CTL_OFF: begin
					next_st.init_request = v[CTL_INIT];
					next_st.sleep_request = v[CTL_SLEEP];
					next_st.fifo_order_select = v[CTL_TFO];
					next_st.auto_wakeup_enable = v[CTL_AWU];
					next_st.ttc = v[CTL_TTC];
				end
				TSTAT_OFF: begin
					// write one to clear; hardware sets come later
					for (int i = 0; i < NUM_MB; i++) begin
						next_st.tstat[i] = st.tstat[i] & ~c[8*i +: 4];
					end
				end
				RF0_OFF, RF1_OFF: begin
					if (c[RF_REL] && st.rf_cnt[awaddr[4]] != 2'h0) begin
						next_st.rf_cnt[awaddr[4]] =
							st.rf_cnt[awaddr[4]] - 2'h1;
						next_st.rf_head[awaddr[4]] =
							st.rf_head[awaddr[4]] == 2'h2 ? 2'h0 :
							st.rf_head[awaddr[4]] + 2'h1;
					end
				end
				BT_OFF: begin
					// options only move while in init mode
					if (st.mode == M_INIT) begin
						next_st.loopback_select = v[BT_LOOP];
						next_st.silent_select = v[BT_SILENT];
					end
				end
				FACT_OFF:  next_st.f_act = v[27:0];
				FFIFO_OFF: next_st.f_fifo = v[27:0];
				default: begin
					// a busy mailbox ignores writes
					if (mi < 8'h03 &&
							st.mb_st[mi[1:0]] == MB_EMPTY) begin
						case (awaddr[3:2])
							2'h0: begin
								next_st.mb_id[mi[1:0]] = v[31:0];
								if (v[MBI_TXREQ]) begin
									next_st.mb_st[mi[1:0]] = MB_PEND;
									next_st.ord[mi[1:0]] = 2'(3 - 32'(
										st.mb_st[0] == MB_EMPTY) - 32'(
										st.mb_st[1] == MB_EMPTY) - 32'(
										st.mb_st[2] == MB_EMPTY));
								end
							end
							2'h1: next_st.mb_prop[mi[1:0]] = v[31:0];
							2'h2: next_st.mb_dlo[mi[1:0]] = v[31:0];
							default: next_st.mb_dhi[mi[1:0]] = v[31:0];
						endcase
					end else if (fi < 12'(NUM_FLT * 8)) begin
						if (awaddr[2]) begin
							next_st.f_mask[fi[7:3]] = v[31:0];
						end else begin
							next_st.f_id[fi[7:3]] = v[31:0];
						end
					end
				end
			endcase
		end
		// register reads
		if (rd_go) begin
			v = rdmux(st, araddr);
			next_st.rvalid = 1'b1;
			next_st.rdata = v[31:0];
			next_st.rresp = v[32] ? RESP_OKAY : RESP_DECERR;
		end
		// working mode; activity on rx wakes when enabled
		if (st.mode == M_SLEEP && st.auto_wakeup_enable && !st.rx_s2) begin
			next_st.sleep_request = 1'b0;
		end
		case (st.mode)
			M_SLEEP: begin
				if (!next_st.sleep_request) begin
					next_st.mode = next_st.init_request ? M_INIT : M_NORM;
				end
			end
			M_INIT: begin
				if (!next_st.init_request) begin
					next_st.mode = next_st.sleep_request ? M_SLEEP : M_NORM;
				end
			end
			M_NORM: begin
				// a frame on the wire is finished before switching
				if ((st.init_request || st.sleep_request) &&
						st.eng == E_IDLE) begin
					next_st.mode = st.init_request ? M_INIT :
						M_SLEEP;
				end
			end
			default: next_st.mode = M_SLEEP;
		endcase
		// protocol engine, one bit each BIT_CYC clocks
		case (st.eng)
			E_IDLE: begin
				next_st.bcnt = 5'h0;
				next_st.bitn = 7'h0;
				// a pending mode change holds off the next frame
				if (st.mode == M_NORM && !st.init_request &&
						!st.sleep_request) begin
					if (!st.loopback_select && !st.rx_s2) begin
						next_st.eng = E_RX;
						next_st.ts = st.timer;
					end else if (any_rdy && !st.silent_select) begin
						next_st.eng = E_TX;
						next_st.cur = sel;
						next_st.mb_st[sel] = MB_TX;
						next_st.ts = st.timer;
						if (st.ttc) begin
							next_st.mb_dhi[sel][31:16] = st.timer;
						end
						next_st.sh = {1'b0, st.mb_id[sel], st.mb_dlo[sel],
							next_st.mb_dhi[sel]};
					end
				end
			end
			E_TX, E_RX: begin
				next_st.bcnt = bit_end ? 5'h0 : st.bcnt + 5'h01;
				if (bit_end) begin
					next_st.sh = {st.sh[95:0], rx_int};
					next_st.bitn = st.bitn + 7'h01;
					if (st.eng == E_TX && rx_int != st.sh[96]) begin
						arb = st.bitn < ARB_END && st.sh[96];
						next_st.tstat[st.cur][TS_SENT] = 1'b1;
						next_st.tstat[st.cur][TS_ARB] = arb;
						next_st.tstat[st.cur][TS_ERR] = !arb;
						next_st.mb_st[st.cur] = st.ttc ? MB_EMPTY :
							MB_SCHED;
						// a lost arbitration keeps receiving the winner
						next_st.eng = arb ? E_RX : E_IDLE;
					end else if (st.bitn == FRAME_LAST) begin
						next_st.eng = E_IDLE;
						if (st.eng == E_TX) begin
							next_st.tstat[st.cur][TS_SENT] = 1'b1;
							next_st.tstat[st.cur][TS_OK] = 1'b1;
							next_st.mb_st[st.cur] = MB_EMPTY;
						end
						if (st.eng == E_RX || st.loopback_select) begin
							// first matching active bank decides
							for (int i = NUM_FLT - 1; i >= 0; i--) begin
								if (st.f_act[i] && ((next_st.sh[95:64] ^
										st.f_id[i]) & st.f_mask[i]) ==
										32'h0) begin
									hit = 1'b1;
									ff = st.f_fifo[i];
								end
							end
							// a full fifo drops the new frame
							if (hit && next_st.rf_cnt[ff] != RF_DEPTH) begin
								slot = 2'((3'(next_st.rf_head[ff]) +
									3'(next_st.rf_cnt[ff])) % 3'h3);
								next_st.rf[ff][slot] = {next_st.sh[95:0],
									st.ts};
								next_st.rf_cnt[ff] =
									next_st.rf_cnt[ff] + 2'h1;
							end
						end
					end
				end
			end
			default: next_st.eng = E_IDLE;
		endcase
		// keep request order dense when a mailbox empties
		for (int i = 0; i < NUM_MB; i++) begin
			if (st.mb_st[i] != MB_EMPTY && next_st.mb_st[i] == MB_EMPTY) begin
				for (int j = 0; j < NUM_MB; j++) begin
					if (next_st.ord[j] > st.ord[i]) begin
						next_st.ord[j] = next_st.ord[j] - 2'h1;
					end
				end
			end
		end
		// several waiting mailboxes go to scheduled
		for (int i = 0; i < NUM_MB; i++) begin
			if (next_st.mb_st[i] == MB_PEND ||
					next_st.mb_st[i] == MB_SCHED) begin
				n_rdy = n_rdy + 2'h1;
			end
		end
		for (int i = 0; i < NUM_MB; i++) begin
			if (next_st.mb_st[i] == MB_PEND && n_rdy > 2'h1) begin
				next_st.mb_st[i] = MB_SCHED;
			end
		end
		// silent or idle holds the pin recessive
		next_st.txpin = (next_st.silent_select ||
			next_st.eng != E_TX) ? 1'b1 : next_st.sh[96];
	end

	// ==========================================================
	// state register
	always_ff @(posedge mclk) begin
		if (rst) begin
			st <= '0;
			st.mode <= M_SLEEP;
			st.sleep_request <= 1'b1;
			st.eng <= E_IDLE;
			st.mb_st <= {3{MB_EMPTY}};
			st.txpin <= 1'b1;
			st.rx_s1 <= 1'b1;
			st.rx_s2 <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// checks
	default clocking dc @(posedge mclk); endclocking
	default disable iff (rst);

	sequence tx_done0;
		st.mb_st[0] == MB_TX ##1 st.mb_st[0] == MB_EMPTY;
	endsequence
	sequence go_init;
		st.mode == M_NORM && st.init_request && st.eng == E_IDLE;
	endsequence

	reset_sleep_a: assert property ($fell(rst) |->
		st.mode == M_SLEEP && !proto_clk_en)
		else $error("not asleep after reset");
	sleep_entry_a: assert property (st.mode != M_SLEEP &&
		st.sleep_request && !st.init_request && st.eng == E_IDLE
		|=> st.mode == M_SLEEP)
		else $error("sleep not entered");
	auto_wake_a: assert property (st.mode == M_SLEEP &&
		st.auto_wakeup_enable && !st.rx_s2 |=> st.mode != M_SLEEP)
		else $error("no wakeup on activity");
	init_entry_a: assert property (go_init |=>
		st.mode == M_INIT ##1 st.mode == M_INIT || !st.init_request)
		else $error("init not entered");
	busy_hold_a: assert property (st.mode == M_NORM &&
		st.eng != E_IDLE |=> st.mode == M_NORM)
		else $error("mode left mid frame");
	idle_hold_a: assert property (st.mode == M_NORM &&
		(st.init_request || st.sleep_request) && st.eng == E_IDLE
		|=> st.eng == E_IDLE)
		else $error("frame started during mode change");
	silent_pin_a: assert property (st.silent_select |-> can_tx)
		else $error("silent mode drove tx");
	one_sender_a: assert property ($onehot0({
		st.mb_st[0] == MB_TX, st.mb_st[1] == MB_TX,
		st.mb_st[2] == MB_TX}))
		else $error("two mailboxes sending");
	sent_flag_a: assert property (tx_done0 |->
		st.tstat[0][TS_SENT])
		else $error("sent flag missing");
	ok_flag_a: assert property ($rose(st.tstat[0][TS_OK]) |->
		st.tstat[0][TS_SENT] && $past(st.mb_st[0]) == MB_TX)
		else $error("ok flag without clean send");
	timer_run_a: assert property (st.mode != M_SLEEP |=>
		st.timer == $past(st.timer) + 16'h0001)
		else $error("timer stalled");
endmodule

// ### can_node.sv
// far-side network node seen through the transceiver
// assumes the controller drives can_tx and reads can_rx, 1 = recessive
`timescale 1ns/1ps
module can_node (
	input  wire logic can_tx,
	input  wire logic dom_en,
	output logic      can_rx
);
	// ==========================================================
	// wired-and bus
	// any node pulling dominant wins; the pull-up gives recessive
	assign can_rx = can_tx & ~dom_en;
endmodule

// ### tb.sv
// self-checking bench for the can controller over AXI4-Lite
// assumes can_cfg_pkg map and a can_node partner on the pins
`timescale 1ns/1ps
module tb;
	import can_cfg_pkg::*;
	localparam logic [31:0] DLO = 32'hA5A5_0F0F;
	logic        mclk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, dom_en;
	logic        can_rx, can_tx, clk_en;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v, x, pv;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rs;
	int          fails, checked, n;
	// ==========================================================
	// design and partner
	can_ctrl dut_u (.mclk(mclk), .rst(rst), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .can_rx(can_rx), .can_tx(can_tx),
		.proto_clk_en(clk_en));
	can_node node_u (.can_tx(can_tx), .dom_en(dom_en), .can_rx(can_rx));
	// ==========================================================
	// clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// ==========================================================
	// bus tasks
	// waits for handshake s at falling edges, returns after taking edge
	// no limit here: only the watchdog ends a wait for the slave
	task automatic hold(input int s);
		do begin
			@(negedge mclk);
		end while (!(s == 0 ? awready === 1'b1 :
			s == 1 ? bvalid === 1'b1 :
			s == 2 ? arready === 1'b1 : rvalid === 1'b1));
		v = rdata;
		rs = s == 1 ? bresp : rresp;
		@(posedge mclk);
	endtask
	// trailing edge keeps a strobe from being set twice in one step
	task automatic w(input logic [11:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		hold(0);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		hold(1);
		bready <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic r(input logic [11:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		hold(2);
		arvalid <= 1'b0;
		hold(3);
		d = v;
		rready <= 1'b0;
		@(posedge mclk);
	endtask
	// rereads a register until bit b sets, bounded
	task automatic poll(input logic [11:0] a, input int b);
		int k;
		k = 0;
		do begin
			r(a, pv);
			k++;
		end while (pv[b] !== 1'b1 && k < 1500);
	endtask
	task automatic chk(input string s, input logic [31:0] got, exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s exp %h seen %h", s, exp, got);
		end
	endtask
	// fill mailbox 0 then request it, id msb recessive
	task automatic ld;
		w(MB_BASE + 12'h4, 32'h0000_0008);
		w(MB_BASE + 12'h8, DLO);
		w(MB_BASE + 12'hC, 32'h1234_5678);
		w(MB_BASE, 32'h8000_0001);
	endtask
	task automatic results;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ==========================================================
	// tests
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, dom_en} = 6'h0;
		{awaddr, araddr, wdata, wstrb} = 60'h0;
		wstrb = 4'hF;
		rst = 1'b1;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		chk("clk_en", {31'h0, clk_en}, 32'h0);
		r(CTL_OFF, x);
		chk("ctl", x, 32'h2);
		r(STAT_OFF, x);
		chk("stat", x, 32'h2);
		r(12'hFFC, x);
		chk("unmapped", {30'h0, rs}, {30'h0, RESP_DECERR});
		w(12'hFFC, 32'h0);
		chk("unmapped wr", {30'h0, rs}, {30'h0, RESP_DECERR});
		$display("test reset done");
		// silent: request pending but the pin must stay recessive
		w(CTL_OFF, 32'h1);
		chk("ctl wr", {30'h0, rs}, {30'h0, RESP_OKAY});
		r(STAT_OFF, x);
		chk("stat init", x, 32'h1);
		w(FACT_OFF, 32'h1);
		w(FLT_BASE, 32'h0);
		w(FLT_BASE + 12'h4, 32'h0);
		w(BT_OFF, 32'h8000_0000);
		ld();
		w(CTL_OFF, 32'h0);
		r(STAT_OFF, x);
		chk("stat norm", x, 32'h0);
		n = 0;
		repeat (300) begin
			@(negedge mclk);
			if (can_tx !== 1'b1)
				n++;
		end
		chk("silent tx", n, 0);
		r(TSTAT_OFF, x);
		chk("silent sent", {31'h0, x[TS_SENT]}, 32'h0);
		$display("test silent done");
		// loopback with the network held dominant: rx must be ignored
		w(CTL_OFF, 32'h1);
		w(BT_OFF, 32'h4000_0000);
		dom_en <= 1'b1;
		w(CTL_OFF, 32'h0);
		poll(TSTAT_OFF, TS_OK);
		chk("tstat", pv & 32'h0400_000F, 32'h0400_0003);
		r(RF0_OFF, x);
		chk("rf0 count", {30'h0, x[1:0]}, 32'h1);
		r(RXM_BASE + 12'h8, x);
		chk("rx data", x, DLO);
		dom_en <= 1'b0;
		$display("test loopback done");
		// arbitration lost after start of frame
		w(TSTAT_OFF, 32'hF);
		w(CTL_OFF, 32'h1);
		w(BT_OFF, 32'h0);
		ld();
		w(CTL_OFF, 32'h0);
		n = 0;
		while (can_tx !== 1'b0 && n < 999) begin
			@(negedge mclk);
			n++;
		end
		@(posedge mclk);
		dom_en <= 1'b1;
		poll(TSTAT_OFF, TS_ARB);
		dom_en <= 1'b0;
		chk("arb", pv & 32'hF, 32'h5);
		$display("test arbitration done");
		// sleep request waits for the frame on the wire
		w(CTL_OFF, 32'h2);
		r(STAT_OFF, x);
		chk("stat busy", x, 32'h0);
		poll(STAT_OFF, STAT_SLEEP);
		chk("stat sleep", pv, 32'h2);
		chk("clk stop", {31'h0, clk_en}, 32'h0);
		$display("test sleep done");
		// bus activity wakes the controller when auto wakeup is on
		w(CTL_OFF, 32'h22);
		dom_en <= 1'b1;
		repeat (4) @(posedge mclk);
		dom_en <= 1'b0;
		r(STAT_OFF, x);
		chk("stat wake", x, 32'h0);
		r(CTL_OFF, x);
		chk("ctl wake", x, 32'h20);
		chk("clk run", {31'h0, clk_en}, 32'h1);
		$display("test wakeup done");
		results();
	end
	// ==========================================================
	// watchdog, well beyond two frame times of work
	initial begin
		repeat (60000) @(posedge mclk);
		fails++;
		results();
	end
endmodule
